// File: dv/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter int TMO = 30,
  parameter int PROG = 50,
  parameter int ERASE = 100,
  parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3C // arbitrary value
) (
  // timer clock
  input wire logic mclk_in,
  // pins
  input wire logic chip_select_n_in,
  input wire logic output_enable_n_in,
  input wire logic write_enable_n_in,
  input wire logic [16:0] addr_in,
  input wire logic [7:0] data_lines_in,
  output logic [7:0] data_lines_out
);
  logic [7:0] mem [logic [16:0]];
  logic [16:0] sa [$];
  logic [7:0] sd [$];
  logic [16:0] la, last_a;
  logic [7:0] ld, q = 8'h00;
  logic prot = 1'b0; // no reset: survives power cycles
  logic idm = 1'b0, tog = 1'b0, wr_d = 1'b0, rd_d = 1'b0;
  int idle = 0, busy = 0, wl = 0;
  wire logic wr = !chip_select_n_in && !write_enable_n_in
    && output_enable_n_in;
  wire logic rd = !chip_select_n_in && !output_enable_n_in;
  assign data_lines_out = q;
  function automatic bit seq(int n, logic [47:0] c);
    seq = sa.size() >= n;
    for (int i = 0; i < n; i++) begin
      if (sd[i] != c[47-8*i -: 8]) seq = 0;
      if (sa[i] != (i % 3 == 1 ? 17'h02AAA : 17'h05555)) seq = 0;
    end
  endfunction
  task automatic finish_load();
    logic [16:0] pg;
    if (sa.size() == 6 && seq(6, 48'hAA5580AA5520)) prot = 0;
    else if (sa.size() == 6 && seq(6, 48'hAA5580AA5510)) begin
      mem.delete();
      busy = ERASE;
    end else if (sa.size() == 6 && seq(6, 48'hAA5580AA5560)) idm = 1;
    else if (sa.size() == 3 && seq(3, 48'hAA55F0000000)) idm = 0;
    else begin
      if (seq(3, 48'hAA55A0000000)) begin
        prot = 1;
        repeat (3) void'(sa.pop_front());
        repeat (3) void'(sd.pop_front());
      end else if (prot) sa.delete();
      if (sa.size() > 0) begin
        pg = sa[0] & 17'h1FF80;
        for (int i = 0; i < 128; i++) mem[pg | i] = 8'hFF;
        foreach (sa[i]) mem[pg | sa[i][6:0]] = sd[i];
        last_a = sa[$];
        busy = PROG;
      end
    end
    sa.delete();
    sd.delete();
  endtask
  function automatic logic [7:0] read_val();
    logic [7:0] v;
    v = mem.exists(addr_in) ? mem[addr_in] : 8'hFF;
    if (idm && addr_in < 2) v = addr_in[0] ? DEV_CODE : MFR_CODE;
    if (busy > 0) v[6] = tog;
    if (busy > 0 && addr_in == last_a) v[7] = ~v[7];
    return v;
  endfunction
  always @(posedge mclk_in) begin
    if (busy > 0) busy--;
    if (wr && !wr_d) la = addr_in;
    if (wr) ld = data_lines_in;
    if (!wr && wr_d && wl > 1 && busy == 0) begin
      sa.push_back(la);
      sd.push_back(ld);
      idle = 0;
    end else if (sa.size() > 0) begin
      idle++;
      if (idle >= TMO) finish_load();
    end
    wl = wr ? wl + 1 : 0;
    if (rd && !rd_d && busy > 0) tog = ~tog;
    // released lines flip every cycle so a stale value never looks valid
    q <= rd ? read_val() : ~q;
    wr_d = wr;
    rd_d = rd;
  end
endmodule // flash_dev_model
`default_nettype wire

// File: dv/flash_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_asserts #(
  parameter int WINDOW_CYC = 20,
  parameter int TIMEOUT_CYC = 40
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // flash pins
  input wire logic chip_select_n_out,
  input wire logic output_enable_n_out,
  input wire logic write_enable_n_out,
  input wire flash_host_pkg::addr_t addr_out,
  input wire flash_host_pkg::byte_t data_lines_out,
  input wire logic data_lines_oe_n_out,
  // user answer
  input wire logic done_out
);
  import flash_host_pkg::*;
  // strobe spacing, fall to fall; saturates so idle gaps stay large
  logic [15:0] gap_r, gap_nxt;
  logic we_d_r, we_d_nxt;
  always_comb begin
    we_d_nxt = write_enable_n_out;
    gap_nxt = (gap_r == 16'hFFFF) ? gap_r : gap_r + 16'h1;
    if (we_d_r && !write_enable_n_out) gap_nxt = 16'h0;
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_r <= 16'hFFFF;
      we_d_r <= 1'b1;
    end else begin
      gap_r <= gap_nxt;
      we_d_r <= we_d_nxt;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_write_oe_high: assert property (
    !write_enable_n_out |-> output_enable_n_out) else $error("oe in write");
  a_write_selected: assert property (
    !write_enable_n_out |-> !chip_select_n_out) else $error("cs in write");
  a_write_drives: assert property (
    !write_enable_n_out |-> !data_lines_oe_n_out) else $error("bus undriven");
  a_read_released: assert property (
    !output_enable_n_out |-> data_lines_oe_n_out) else $error("bus fight");
  a_read_held: assert property (
    $fell(output_enable_n_out) |-> (!output_enable_n_out && !chip_select_n_out)
    [*6]) else $error("read cut short");
  a_strobe_stable: assert property (
    !write_enable_n_out && !$past(write_enable_n_out) |-> $stable(addr_out)
    && $stable(data_lines_out)) else $error("bus moved in strobe");
  a_strobe_width: assert property (
    $fell(write_enable_n_out) |-> !write_enable_n_out[*6])
    else $error("strobe too short");
  a_load_window: assert property (
    $fell(write_enable_n_out) |-> gap_r < WINDOW_CYC || gap_r >= TIMEOUT_CYC)
    else $error("load gap ambiguous");
  c_write: cover property ($fell(write_enable_n_out));
  c_read: cover property ($fell(output_enable_n_out));
  c_done: cover property (done_out);
endmodule // flash_host_asserts
bind flash_host flash_host_asserts #(.WINDOW_CYC(WINDOW_CYC),
  .TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (.mclk_in, .rst_in, .chip_select_n_out,
  .output_enable_n_out, .write_enable_n_out, .addr_out, .data_lines_out,
  .data_lines_oe_n_out, .done_out);
`default_nettype wire

// File: dv/flash_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_tb;
  import flash_host_pkg::*;
  logic mclk_in = 0, rst_in = 1, req_valid_in = 0, req_prot_in = 0;
  logic fill_en_in = 0, req_ready_out, done_out, cs_n, oe_n, we_n, doe_n;
  logic [6:0] fill_idx_in = 0;
  host_op_t req_op_in = OP_READ;
  addr_t req_addr_in = 0, a;
  byte_t fill_data_in = 0, rd_data_out, hd, dd;
  wire byte_t bus = doe_n ? dd : hd;
  int mismatches = 0, tests_run = 0, cyc = 0;
  always #5 mclk_in = ~mclk_in;
  flash_host #(.WINDOW_CYC(20), .TIMEOUT_CYC(40), .PAUSE_CYC(60),
    .ERASE_CYC(200)) dut_u (.mclk_in, .rst_in, .req_valid_in, .req_ready_out,
    .req_op_in, .req_addr_in, .req_prot_in, .fill_en_in, .fill_idx_in,
    .fill_data_in, .done_out, .rd_data_out, .chip_select_n_out(cs_n),
    .output_enable_n_out(oe_n), .write_enable_n_out(we_n), .addr_out(a),
    .data_lines_out(hd), .data_lines_oe_n_out(doe_n), .data_lines_in(bus));
  flash_dev_model dev_u (.mclk_in, .chip_select_n_in(cs_n),
    .output_enable_n_in(oe_n), .write_enable_n_in(we_n), .addr_in(a),
    .data_lines_in(bus), .data_lines_out(dd));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic op(input host_op_t o, input addr_t ad, input logic p);
    int n;
    @(posedge mclk_in);
    req_op_in <= o;
    req_addr_in <= ad;
    req_prot_in <= p;
    req_valid_in <= 1;
    @(posedge mclk_in);
    req_valid_in <= 0;
    for (n = 0; n < 9000 && done_out !== 1'b1; n++) @(negedge mclk_in);
    check(n < 9000, 1);
  endtask
  task automatic rd(input addr_t ad, input byte_t exp);
    op(OP_READ, ad, 0);
    check(rd_data_out, exp);
  endtask
  task automatic fill(input byte_t seed);
    for (int i = 0; i < 128; i++) begin
      @(posedge mclk_in);
      fill_en_in <= 1;
      fill_idx_in <= i[6:0];
      fill_data_in <= seed ^ i[7:0];
    end
    @(posedge mclk_in);
    fill_en_in <= 0;
  endtask
  task automatic t_page();
    fill(8'h3C);
    op(OP_PAGE, 17'h00280, 0);
    check(dev_u.busy, 0);
    rd(17'h00280, 8'h3C);
    rd(17'h002FF, 8'h43);
    rd(17'h00300, 8'hFF);
  endtask
  task automatic t_prot();
    fill(8'hA5);
    op(OP_PAGE, 17'h1FF80, 1);
    check(dev_u.prot, 1);
    rd(17'h1FF81, 8'hA4);
    @(posedge mclk_in);
    rst_in <= 1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 0;
    // host forgot protection; device must still refuse the bare page
    fill(8'h91);
    op(OP_PAGE, 17'h1FF80, 0);
    rd(17'h1FF80, 8'hA5);
    op(OP_PROT_OFF, 17'h00000, 0);
    check(dev_u.prot, 0);
  endtask
  task automatic t_erase();
    op(OP_PROT_ON, 17'h00000, 0);
    check(dev_u.prot, 1);
    op(OP_PROT_OFF, 17'h00000, 0);
    check(dev_u.prot, 0);
    op(OP_ERASE, 17'h00000, 0);
    rd(17'h00280, 8'hFF);
  endtask
  task automatic t_id();
    op(OP_ID_ENTER, 17'h00000, 0);
    rd(17'h00000, 8'h5A);
    rd(17'h00001, 8'h3C);
    op(OP_ID_EXIT, 17'h00000, 0);
    rd(17'h00000, 8'hFF);
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_in <= 0;
    t_page();
    t_prot();
    t_erase();
    t_id();
    print_verdict();
  end
endmodule // flash_host_tb
`default_nettype wire

// File: src/flash_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.svh"
// Summary of operation
// [R1] device drives data only with chip select and output enable low
// [R2] whole 128-byte pages; host loads every byte, unloaded ones become FFh
// [R3] write strobe: chip select and write enable low, output enable high
// [R4] device latches address on later falling edge of select or write
// [R5] device latches data on first rising edge of select or write
// [R6] host loads each next byte within 200 us of the previous one
// [R7] device programs page after 300 us with no new write strobe
// [R8] upper address bits pick page, low seven bits pick byte, one page each
// [R9] page bytes may arrive in any order
// [R10] device programs all 128 buffered bytes at once by itself
// [R11] protected device needs three-byte command before each page
// [R12] device starts unprotected; three-byte command prefix enables protection
// [R13] protection persists across power until disable sequence
// [R14] six-byte sequence returns device to unprotected mode
// [R15] write enable pulses under 15 ns are ignored as glitches
// [R16] writes blocked with output enable low, select high or write high
// [R17] during programming, last byte reads back with bit 7 inverted
// [R18] during programming, bit 6 toggles on each read
// [R19] six-byte chip erase completes within 50 ms unassisted
// [R20] identification mode: address 0 maker code, address 1 part code
// [R21] three-byte exit sequence leaves identification mode
// [R22] hardware id: select, output low, write high, id line at 12 V; the host has no id line and reads the codes only after the R25 entry sequence
// [R23] protect on AA/55/A0, off AA/55/80/AA/55/20 at 5555/2AAA
// [R24] erase AA/55/80/AA/55/10 at alternating command addresses; the code sends them at 5555/2AAA/5555/5555/2AAA/5555
// [R25] id entry ends 80/AA/55/60, exit AA/55/F0; then 10 us pause
// [R26] device ignores loads and commands while programming or erasing
module flash_host
  import flash_host_pkg::*;
#(
  parameter int STROBE_CYC = `STROBE_CYC,
  parameter int WINDOW_CYC = `BYTE_LOAD_WINDOW_CYC,
  parameter int TIMEOUT_CYC = `BYTE_LOAD_TIMEOUT_CYC,
  parameter int PAUSE_CYC = `ID_PAUSE_CYC,
  parameter int ERASE_CYC = `ERASE_TIME_CYC
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // user command
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire flash_host_pkg::host_op_t req_op_in,
  input wire flash_host_pkg::addr_t req_addr_in,
  input wire logic req_prot_in,
  // user page fill
  input wire logic fill_en_in,
  input wire logic [6:0] fill_idx_in,
  input wire flash_host_pkg::byte_t fill_data_in,
  // user answer
  output logic done_out,
  output flash_host_pkg::byte_t rd_data_out,
  // flash pins
  output logic chip_select_n_out,
  output logic output_enable_n_out,
  output logic write_enable_n_out,
  output flash_host_pkg::addr_t addr_out,
  output flash_host_pkg::byte_t data_lines_out,
  output logic data_lines_oe_n_out,
  input wire flash_host_pkg::byte_t data_lines_in
);
  import flash_host_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_LOAD, S_PROG, S_POLL, S_RD, S_WAIT, S_DONE
  } st_t;
  typedef enum logic [1:0] {PH_SET, PH_LOW, PH_HIGH} ph_t;

  localparam int CW = 24;
  localparam logic [CW-1:0] STB = CW'(STROBE_CYC);

  st_t st_r, st_nxt;
  ph_t ph_r, ph_nxt;
  host_op_t op_r, op_nxt;
  addr_t addr_r, addr_nxt;
  logic prot_r, prot_nxt;
  logic [2:0] seq_r, seq_nxt;
  logic [7:0] idx_r, idx_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [7:0] sync1_r, sync2_r;
  byte_t last_r, last_nxt;
  byte_t rd_r, rd_nxt;
  logic cs_n_r, cs_n_nxt, we_n_r, we_n_nxt, oe_n_r, oe_n_nxt;
  logic drv_r, drv_nxt;
  addr_t pa_r, pa_nxt;
  byte_t pd_r, pd_nxt;
  byte_t buf_q;
  logic [2:0] seq_len;
  addr_t seq_a;
  byte_t seq_d;

  page_store #(.DEPTH(`PAGE_BYTES), .AW(7)) u_store (
    .mclk_in(mclk_in),
    .wr_en_in(fill_en_in),
    .wr_addr_in(fill_idx_in),
    .wr_data_in(fill_data_in),
    // next index, so the registered read already holds the byte to send
    .rd_addr_in(idx_nxt[6:0]),
    .rd_data_out(buf_q)
  );

  // command byte table per operation
  always_comb begin
    seq_a = (seq_r == 3'd1 || seq_r == 3'd4) ? `CMD_ADDR_B : `CMD_ADDR_A; // [R23]
    seq_d = `CMD_D_AA;
    seq_len = 3'd0;
    case (seq_r)
      3'd1, 3'd4: seq_d = `CMD_D_55;
      3'd2: begin
        case (op_r)
          OP_PAGE, OP_PROT_ON: seq_d = `CMD_D_A0; // [R11] [R12]
          OP_ID_EXIT: seq_d = `CMD_D_F0; // [R21]
          default: seq_d = `CMD_D_80;
        endcase
      end
      3'd5: begin
        case (op_r)
          OP_ERASE: seq_d = `CMD_D_10; // [R24]
          OP_ID_ENTER: seq_d = `CMD_D_60; // [R25]
          default: seq_d = `CMD_D_20; // [R14]
        endcase
      end
      default: seq_d = `CMD_D_AA;
    endcase
    case (op_r)
      OP_PAGE: seq_len = prot_r ? 3'd3 : 3'd0;
      OP_PROT_ON, OP_ID_EXIT: seq_len = 3'd3;
      OP_PROT_OFF, OP_ERASE, OP_ID_ENTER: seq_len = 3'd6;
      default: seq_len = 3'd0;
    endcase
  end

  // sequencer
  always_comb begin
    st_nxt = st_r;
    ph_nxt = ph_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    prot_nxt = prot_r;
    seq_nxt = seq_r;
    idx_nxt = idx_r;
    cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    last_nxt = last_r;
    rd_nxt = rd_r;
    cs_n_nxt = cs_n_r;
    we_n_nxt = we_n_r;
    oe_n_nxt = oe_n_r;
    drv_nxt = drv_r;
    pa_nxt = pa_r;
    pd_nxt = pd_r;
    case (st_r)
      S_IDLE: begin
        cs_n_nxt = 1'b1;
        we_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        drv_nxt = 1'b0;
        if (req_valid_in) begin
          op_nxt = req_op_in;
          addr_nxt = req_addr_in;
          seq_nxt = '0;
          idx_nxt = '0;
          ph_nxt = PH_SET;
          if (req_op_in == OP_READ) begin
            st_nxt = S_RD;
          end else begin
            st_nxt = S_CMD;
          end
          if (req_op_in == OP_PAGE) begin
            prot_nxt = req_prot_in | prot_r; // [R13]
          end
        end
      end
      // byte write strobe shared by command and page bytes
      S_CMD, S_LOAD: begin
        case (ph_r)
          PH_SET: begin
            oe_n_nxt = 1'b1; // [R3] [R16]
            drv_nxt = 1'b1;
            if (st_r == S_CMD) begin
              pa_nxt = seq_a;
              pd_nxt = seq_d;
            end else begin
              pa_nxt = {addr_r[16:7], idx_r[6:0]}; // [R8] [R9]
              pd_nxt = buf_q; // [R2]
            end
            ph_nxt = PH_LOW;
            cnt_nxt = STB;
            if (st_r == S_CMD && seq_r >= seq_len) begin
              ph_nxt = PH_SET;
              if (op_r == OP_PAGE) begin
                st_nxt = S_LOAD;
              end else begin
                st_nxt = S_WAIT;
                // release the data lines for the whole pause
                drv_nxt = 1'b0;
                cnt_nxt = (op_r == OP_ERASE) ? CW'(ERASE_CYC)
                                             : CW'(PAUSE_CYC); // [R19] [R25]
              end
            end
          end
          PH_LOW: begin
            cs_n_nxt = 1'b0;
            we_n_nxt = 1'b0; // [R3]
            // low held well past the glitch limit
            if (cnt_r == '0) begin // [R15]
              we_n_nxt = 1'b1;
              cs_n_nxt = 1'b1;
              ph_nxt = PH_HIGH;
              cnt_nxt = STB;
            end
          end
          default: begin
            if (cnt_r == '0) begin
              drv_nxt = 1'b0;
              ph_nxt = PH_SET;
              if (st_r == S_CMD) begin
                seq_nxt = seq_r + 3'd1;
                if (op_r == OP_PROT_ON) prot_nxt = 1'b1; // [R12]
                if (op_r == OP_PROT_OFF) prot_nxt = 1'b0; // [R14]
              end else begin
                last_nxt = pd_r;
                idx_nxt = idx_r + 8'd1;
                // next byte well inside the load window
                if (idx_r == 8'(`PAGE_BYTES - 1)) begin // [R6] [R10]
                  st_nxt = S_PROG;
                  cnt_nxt = CW'(TIMEOUT_CYC); // [R7]
                end
              end
            end
          end
        endcase
      end
      S_PROG: begin
        if (cnt_r == '0) begin
          st_nxt = S_POLL;
          ph_nxt = PH_SET;
        end
      end
      // poll last byte until completion bit shows true data
      S_POLL, S_RD: begin
        case (ph_r)
          PH_SET: begin
            drv_nxt = 1'b0;
            pa_nxt = (st_r == S_POLL) ? {addr_r[16:7], 7'h7F} : addr_r;
            cs_n_nxt = 1'b0;
            oe_n_nxt = 1'b0; // [R1] [R20] [R22]
            cnt_nxt = STB + 3'd2;
            ph_nxt = PH_LOW;
          end
          PH_LOW: begin
            if (cnt_r == '0) begin
              rd_nxt = sync2_r;
              cs_n_nxt = 1'b1;
              oe_n_nxt = 1'b1;
              ph_nxt = PH_HIGH;
              cnt_nxt = STB;
            end
          end
          default: begin
            if (cnt_r == '0) begin
              ph_nxt = PH_SET;
              if (st_r == S_RD ||
                  rd_r[`POLL_BIT] == last_r[`POLL_BIT]) begin // [R17] [R26]
                st_nxt = S_DONE;
              end
            end
          end
        endcase
      end
      S_WAIT: begin
        if (cnt_r == '0) st_nxt = S_DONE; // [R26]
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= S_IDLE;
      ph_r <= PH_SET;
      op_r <= OP_READ;
      addr_r <= '0;
      prot_r <= 1'b0;
      seq_r <= '0;
      idx_r <= '0;
      cnt_r <= '0;
      last_r <= '0;
      rd_r <= '0;
      cs_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      drv_r <= 1'b0;
      pa_r <= '0;
      pd_r <= '0;
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      prot_r <= prot_nxt;
      seq_r <= seq_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      last_r <= last_nxt;
      rd_r <= rd_nxt;
      cs_n_r <= cs_n_nxt;
      we_n_r <= we_n_nxt;
      oe_n_r <= oe_n_nxt;
      drv_r <= drv_nxt;
      pa_r <= pa_nxt;
      pd_r <= pd_nxt;
      sync1_r <= data_lines_in;
      sync2_r <= sync1_r;
    end
  end

  assign req_ready_out = (st_r == S_IDLE);
  assign done_out = (st_r == S_DONE);
  assign rd_data_out = rd_r;
  assign chip_select_n_out = cs_n_r;
  assign output_enable_n_out = oe_n_r;
  assign write_enable_n_out = we_n_r;
  assign addr_out = pa_r;
  assign data_lines_out = pd_r;
  assign data_lines_oe_n_out = ~drv_r;
endmodule // flash_host
`default_nettype wire

// File: src/flash_host_pkg.sv
package flash_host_pkg;
  typedef enum logic [2:0] {
    OP_READ, OP_PAGE, OP_PROT_ON, OP_PROT_OFF, OP_ERASE, OP_ID_ENTER,
    OP_ID_EXIT
  } host_op_t;
  typedef logic [16:0] addr_t;
  typedef logic [7:0] byte_t;
endpackage

// File: src/flash_host_regs.svh
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

`define PAGE_BYTES 128
`define ERASED_BYTE 8'hFF
`define CMD_ADDR_A 17'h05555
`define CMD_ADDR_B 17'h02AAA
`define CMD_D_AA 8'hAA
`define CMD_D_55 8'h55
`define CMD_D_A0 8'hA0
`define CMD_D_80 8'h80
`define CMD_D_20 8'h20
`define CMD_D_10 8'h10
`define CMD_D_60 8'h60
`define CMD_D_F0 8'hF0
`define ID_MFR_ADDR 17'h00000
`define ID_DEV_ADDR 17'h00001
`define CLK_PERIOD_NS 10
`define BYTE_LOAD_WINDOW_US 200
`define BYTE_LOAD_WINDOW_CYC ((`BYTE_LOAD_WINDOW_US*1000)/`CLK_PERIOD_NS)
`define BYTE_LOAD_TIMEOUT_US 300
`define BYTE_LOAD_TIMEOUT_CYC ((`BYTE_LOAD_TIMEOUT_US*1000)/`CLK_PERIOD_NS)
`define ID_PAUSE_US 10
`define ID_PAUSE_CYC ((`ID_PAUSE_US*1000)/`CLK_PERIOD_NS)
`define ERASE_TIME_MS 50
`define ERASE_TIME_CYC ((`ERASE_TIME_MS*1000000)/`CLK_PERIOD_NS)
`define STROBE_NS 60
`define STROBE_CYC ((`STROBE_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define GLITCH_NS 15
`define POLL_BIT 7
`define TOGGLE_BIT 6

`endif

// File: src/page_store.sv
`timescale 1ns/1ps
`default_nettype none
module page_store #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // clock
  input wire logic mclk_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  // read port
  input wire logic [AW-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge mclk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule // page_store
`default_nettype wire
